/* File: common/lpi_link_pkg.sv */
// lpi link supervision: constants, register map, timer limits and encodings.
// assumes a 250 mhz symbol clock; times are held in ns and turned into cycles here.
package lpi_link_pkg;

   localparam int unsigned CLK_PERIOD_NS = 4;

   // qualification interval and lpi timers, shortest legal time in ns
   localparam int unsigned QUALIFY_NS    = 330000;
   localparam int unsigned RX_TI_NS      = 800;
   localparam int unsigned RX_TQ_NS      = 24000000;
   localparam int unsigned RX_TS_NS      = 240000;
   localparam int unsigned RX_TW_NS      = 30000;
   localparam int unsigned TX_TQ_NS      = 20000000;
   localparam int unsigned TX_TS_NS      = 200000;
   localparam int unsigned LINK_FAIL_NS  = 90000;

   localparam int unsigned QUALIFY_CYC   = (QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RX_TI_CYC     = (RX_TI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RX_TQ_CYC     = (RX_TQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RX_TS_CYC     = (RX_TS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RX_TW_CYC     = (RX_TW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TX_TQ_CYC     = (TX_TQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TX_TS_CYC     = (TX_TS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LINK_FAIL_CYC = (LINK_FAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int unsigned CNT_W   = 23;
   localparam int unsigned NUM_TMR = 7;

   // timer indices on timer_start / timer_expired
   localparam int unsigned TMR_RX_TI     = 0;
   localparam int unsigned TMR_RX_TQ     = 1;
   localparam int unsigned TMR_RX_TS     = 2;
   localparam int unsigned TMR_RX_TW     = 3;
   localparam int unsigned TMR_TX_TQ     = 4;
   localparam int unsigned TMR_TX_TS     = 5;
   localparam int unsigned TMR_LINK_FAIL = 6;

   // register map
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_WAKE_ERR = 8'h08;
   localparam int unsigned CTRL_LPI_EN   = 0;
   localparam int unsigned CTRL_AN_PRES  = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h3;
   localparam logic [15:0] WAKE_ERR_RESET = 16'h0000;

   // far-end fault indication: 17 code groups of 5 bits, 84 ones then one zero
   localparam logic [4:0]  FEF_LAST_GROUP = 5'h10;
   localparam logic [4:0]  FEF_ONES       = 5'h1f;
   localparam logic [4:0]  FEF_TAIL       = 5'h0f;

   typedef enum logic [1:0] {
      LINK_FAIL  = 2'h0,
      LINK_READY = 2'h1,
      LINK_OK    = 2'h2
   } link_status_t;

   typedef enum logic [1:0] {
      CTL_DISABLE = 2'h0,
      CTL_SCAN    = 2'h1,
      CTL_ENABLE  = 2'h2
   } link_control_t;

endpackage

/* File: hw/lpi_link_monitor.sv */
// lpi link supervision: link monitor, far-end fault generator, quiet
// indications to the pmd and the seven lpi timers, with a plain register port.
// assumes the pcs state machines and auto-negotiation share clk; signal_status
// arrives from the pmd asynchronously.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - signal off in normal operation forces fail
// - link_control disable forces link_status fail
// - lpi_link_fail in low power rx forces fail
// - qualify after signal on for 330 us
// - qualified link reports ready to auto-negotiation unless link_control is already enable
// - without auto-negotiation link_control is always enable
// - signal on passes transmit code bits unchanged once any fault cycle in progress has finished
// - signal off outside lpi sends whole fault cycles
// - rx_quiet only in low power quiet receive
// - tx_quiet only in low power quiet transmit
// - rx idle timer expires within 0.8-0.9 us
// - rx quiet timer expires within 24-26 ms
// - rx sleep timer expires within 240-260 us
// - rx wake timer expires within 30-36 us
// - tx quiet timer expires within 20-22 ms
// - tx sleep timer expires within 200-220 us
// - link fail timer expires within 90-110 us
// - rx quiet timer expiry declares link failure
// - wake timer expiry without symbols counts error
// - tx quiet expiry wakes transmitter for refresh
// - tx sleep expiry moves transmitter to quiet
module lpi_link_monitor #(
   parameter logic [lpi_link_pkg::CNT_W-1:0] QUALIFY_CYCLES   = lpi_link_pkg::CNT_W'(lpi_link_pkg::QUALIFY_CYC),
   parameter logic [lpi_link_pkg::CNT_W-1:0] RX_TQ_CYCLES     = lpi_link_pkg::CNT_W'(lpi_link_pkg::RX_TQ_CYC),
   parameter logic [lpi_link_pkg::CNT_W-1:0] RX_TS_CYCLES     = lpi_link_pkg::CNT_W'(lpi_link_pkg::RX_TS_CYC),
   parameter logic [lpi_link_pkg::CNT_W-1:0] RX_TW_CYCLES     = lpi_link_pkg::CNT_W'(lpi_link_pkg::RX_TW_CYC),
   parameter logic [lpi_link_pkg::CNT_W-1:0] TX_TQ_CYCLES     = lpi_link_pkg::CNT_W'(lpi_link_pkg::TX_TQ_CYC),
   parameter logic [lpi_link_pkg::CNT_W-1:0] TX_TS_CYCLES     = lpi_link_pkg::CNT_W'(lpi_link_pkg::TX_TS_CYC),
   parameter logic [lpi_link_pkg::CNT_W-1:0] LINK_FAIL_CYCLES = lpi_link_pkg::CNT_W'(lpi_link_pkg::LINK_FAIL_CYC)
) (
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire logic                                signal_status,
   input  wire lpi_link_pkg::link_control_t         link_control,
   input  wire logic                                lpi_link_fail,
   input  wire logic                                rx_lpi,
   input  wire logic                                rx_line_quiet,
   input  wire logic                                tx_lpi,
   input  wire logic                                tx_line_quiet,
   input  wire logic                                wake_symbols_seen,
   input  wire logic [4:0]                          tx_code_bits,
   input  wire logic [lpi_link_pkg::NUM_TMR-1:0]    timer_start,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [31:0]                         reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output var lpi_link_pkg::link_status_t           link_status,
   output logic [4:0]                               fef_code_bits,
   output logic                                     rx_quiet,
   output logic                                     tx_quiet,
   output logic [lpi_link_pkg::NUM_TMR-1:0]         timer_expired,
   output logic                                     tx_refresh_wake,
   output logic                                     tx_enter_quiet,
   output logic [31:0]                              reg_rdata
);
   import lpi_link_pkg::*;

   typedef enum logic [1:0] {
      ST_DOWN,
      ST_QUALIFY,
      ST_WAIT_ENABLE,
      ST_UP
   } mon_state_t;

   // signal_status synchroniser, a change counts once stages two and three agree
   logic sig_meta;
   logic sig_s2;
   logic sig_s3;
   logic sig_on;

   always_ff @(posedge clk) begin
      if (rst) begin
         sig_meta <= 1'b0;
         sig_s2   <= 1'b0;
         sig_s3   <= 1'b0;
         sig_on   <= 1'b0;
      end else begin
         sig_meta <= signal_status;
         sig_s2   <= sig_meta;
         sig_s3   <= sig_s2;
         if (sig_s2 == sig_s3) begin
            sig_on <= sig_s3;
         end
      end
   end

   // control register and register port
   logic [1:0]  ctrl;
   logic [15:0] wake_err;
   logic        fef_active;
   wire         lpi_en     = ctrl[CTRL_LPI_EN];
   wire         an_present = ctrl[CTRL_AN_PRES];
   wire         wr_ctrl    = reg_wr && (reg_addr == ADDR_CTRL);
   wire         wr_wake    = reg_wr && (reg_addr == ADDR_WAKE_ERR);
   wire [31:0]  status_word = {26'h0, sig_on, fef_active, tx_quiet, rx_quiet, link_status};
   wire [31:0]  rd_word = (reg_addr == ADDR_CTRL)     ? {30'h0, ctrl} :
                          (reg_addr == ADDR_STATUS)   ? status_word :
                          (reg_addr == ADDR_WAKE_ERR) ? {16'h0, wake_err} : 32'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl      <= CTRL_RESET;
         reg_rdata <= 32'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata[1:0];
         end
         reg_rdata <= reg_rd ? rd_word : 32'h0;
      end
   end

   // lpi timers, one counter each
   logic [CNT_W-1:0] limit [NUM_TMR];
   assign limit[TMR_RX_TI]     = CNT_W'(RX_TI_CYC);
   assign limit[TMR_RX_TQ]     = RX_TQ_CYCLES;
   assign limit[TMR_RX_TS]     = RX_TS_CYCLES;
   assign limit[TMR_RX_TW]     = RX_TW_CYCLES;
   assign limit[TMR_TX_TQ]     = TX_TQ_CYCLES;
   assign limit[TMR_TX_TS]     = TX_TS_CYCLES;
   assign limit[TMR_LINK_FAIL] = LINK_FAIL_CYCLES;

   logic [NUM_TMR-1:0] tmr_run;

   for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
      logic [CNT_W-1:0] cnt;
      wire              at_end = (cnt == limit[i] - 1'b1);
      always_ff @(posedge clk) begin
         if (rst || !lpi_en) begin
            cnt              <= '0;
            tmr_run[i]       <= 1'b0;
            timer_expired[i] <= 1'b0;
         end else if (timer_start[i]) begin
            cnt              <= '0;
            tmr_run[i]       <= 1'b1;
            timer_expired[i] <= 1'b0;
         end else if (tmr_run[i]) begin
            if (at_end) begin
               tmr_run[i]       <= 1'b0;
               timer_expired[i] <= 1'b1;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end

   // transmit timer consequences
   assign tx_refresh_wake = tx_lpi && timer_expired[TMR_TX_TQ];
   assign tx_enter_quiet  = tx_lpi && timer_expired[TMR_TX_TS];

   // wake error counter, bumped once per wake timer expiry without wake symbols seen; count wins over clear
   logic tw_seen;
   wire  tw_rise  = timer_expired[TMR_RX_TW] && !tw_seen;
   wire  wake_bad = tw_rise && !wake_symbols_seen;

   always_ff @(posedge clk) begin
      if (rst) begin
         tw_seen  <= 1'b0;
         wake_err <= WAKE_ERR_RESET;
      end else begin
         tw_seen <= timer_expired[TMR_RX_TW];
         if (wake_bad) begin
            wake_err <= wake_err + 1'b1;
         end else if (wr_wake) begin
            wake_err <= WAKE_ERR_RESET;
         end
      end
   end

   // link monitor
   mon_state_t       state;
   mon_state_t       next_state;
   logic [CNT_W-1:0] qual_cnt;
   wire              lpi_rx       = lpi_en && rx_lpi;
   wire              rx_quiet_exp = lpi_rx && timer_expired[TMR_RX_TQ];
   wire              ctl_enable   = !an_present || (link_control == CTL_ENABLE);
   wire              ctl_disable  = an_present && (link_control == CTL_DISABLE);
   wire              sig_lost     = !sig_on && !lpi_rx;
   wire              lpi_fail     = lpi_rx && (lpi_link_fail || rx_quiet_exp);
   wire              force_down   = ctl_disable || sig_lost || lpi_fail;
   wire              qualified    = (qual_cnt == QUALIFY_CYCLES - 1'b1);

   always_comb begin
      next_state = state;
      if (force_down) begin
         next_state = ST_DOWN;
      end else begin
         unique case (state)
            ST_DOWN: begin
               if (sig_on) begin
                  next_state = ST_QUALIFY;
               end
            end
            ST_QUALIFY: begin
               if (qualified) begin
                  next_state = ctl_enable ? ST_UP : ST_WAIT_ENABLE;
               end
            end
            ST_WAIT_ENABLE: begin
               if (ctl_enable) begin
                  next_state = ST_UP;
               end
            end
            ST_UP: begin
               next_state = ST_UP;
            end
         endcase
      end
   end

   wire link_status_t next_link_status = (next_state == ST_UP)          ? LINK_OK :
                                         (next_state == ST_WAIT_ENABLE) ? LINK_READY : LINK_FAIL;

   always_ff @(posedge clk) begin
      if (rst) begin
         state       <= ST_DOWN;
         link_status <= LINK_FAIL;
         qual_cnt    <= '0;
      end else begin
         state       <= next_state;
         link_status <= next_link_status;
         qual_cnt    <= (state == ST_QUALIFY && next_state == ST_QUALIFY) ? qual_cnt + 1'b1 : '0;
      end
   end

   // far-end fault generator: whole indication cycles while signal is lost
   logic [4:0] fef_group;
   wire        fef_want  = !sig_on && !lpi_rx;
   wire        fef_last  = (fef_group == FEF_LAST_GROUP);
   wire [4:0]  fef_word  = fef_last ? FEF_TAIL : FEF_ONES;
   wire        fef_go    = fef_active || fef_want;

   always_ff @(posedge clk) begin
      if (rst) begin
         fef_active    <= 1'b0;
         fef_group     <= 5'h00;
         fef_code_bits <= 5'h00;
      end else begin
         if (fef_go) begin
            fef_code_bits <= fef_word;
            fef_group     <= fef_last ? 5'h00 : fef_group + 1'b1;
            fef_active    <= !(fef_last && !fef_want);
         end else begin
            fef_code_bits <= tx_code_bits;
         end
      end
   end

   // quiet indications to the pmd
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_quiet <= 1'b0;
         tx_quiet <= 1'b0;
      end else begin
         rx_quiet <= lpi_rx && rx_line_quiet;
         tx_quiet <= lpi_en && tx_lpi && tx_line_quiet;
      end
   end

   // cycles since the idle timer was started, saturating; feeds the length checks
   logic [8:0] ti_age;

   always_ff @(posedge clk) begin
      if (rst || !lpi_en) begin
         ti_age <= 9'h000;
      end else if (timer_start[TMR_RX_TI]) begin
         ti_age <= 9'h001;
      end else if (ti_age != 9'h000 && ti_age != 9'h1ff) begin
         ti_age <= ti_age + 9'h001;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_sig_off_fail: assert property (sig_lost |=> link_status == LINK_FAIL)
      else $error("signal lost but link not failed");
   a_disable_fail: assert property (ctl_disable |=> link_status == LINK_FAIL)
      else $error("link_control disable did not fail link");
   a_lpi_fail: assert property (lpi_en && rx_lpi && lpi_link_fail |=> link_status == LINK_FAIL)
      else $error("lpi link fail ignored");
   a_qualify_min: assert property ($rose(state == ST_QUALIFY) |-> (link_status == LINK_FAIL) [*8])
      else $error("link qualified too early");
   a_ready_before_up: assert property (an_present && $rose(link_status == LINK_OK) |->
                                       $past(link_status) == LINK_READY || $past(link_control) == CTL_ENABLE)
      else $error("link up without enable");
   a_ready_shown: assert property (state == ST_QUALIFY && qualified && !force_down && !ctl_enable |=>
                                   link_status == LINK_READY)
      else $error("qualified link not ready");
   a_fef_pass: assert property (!fef_go |=> fef_code_bits == $past(tx_code_bits))
      else $error("code bits not passed through");
   a_fef_tail: assert property (fef_go && fef_last |=> fef_code_bits == FEF_TAIL ##1 fef_active || fef_code_bits != FEF_TAIL)
      else $error("fault cycle tail missing");
   a_rx_quiet: assert property (rx_quiet |-> $past(lpi_en && rx_lpi && rx_line_quiet))
      else $error("rx_quiet outside quiet receive");
   a_tx_quiet: assert property (tx_quiet |-> $past(tx_lpi && tx_line_quiet))
      else $error("tx_quiet outside quiet transmit");
   a_idle_timer: assert property (ti_age == 9'(RX_TI_CYC + 1) |-> timer_expired[TMR_RX_TI])
      else $error("idle timer length wrong");
   a_idle_not_early: assert property (ti_age != 9'h000 && ti_age <= 9'(RX_TI_CYC) |->
                                      !timer_expired[TMR_RX_TI])
      else $error("idle timer expired early");
   a_idle_early: assert property (lpi_en && timer_start[TMR_RX_TI] |=> !timer_expired[TMR_RX_TI] [*8])
      else $error("timer expired too soon");
   a_quiet_exp_fail: assert property (rx_quiet_exp |=> link_status == LINK_FAIL)
      else $error("rx quiet expiry not failing link");
   a_wake_count: assert property (wake_bad |=> wake_err == $past(wake_err) + 16'h1)
      else $error("wake error not counted");
   a_tx_wake: assert property (tx_lpi && timer_expired[TMR_TX_TQ] |-> tx_refresh_wake)
      else $error("no refresh wake");
   a_tx_sleep: assert property (tx_lpi && timer_expired[TMR_TX_TS] |-> tx_enter_quiet)
      else $error("no quiet entry");
   a_expiry_holds: assert property (timer_expired[TMR_LINK_FAIL] && lpi_en && !timer_start[TMR_LINK_FAIL] |=>
                                    timer_expired[TMR_LINK_FAIL])
      else $error("expiry level dropped");
   a_fef_start: assert property (fef_want && !fef_active |=> fef_code_bits == FEF_ONES)
      else $error("fault cycle not started at first group");
   a_quiet_off: assert property (!lpi_en |=> !rx_quiet && !tx_quiet)
      else $error("quiet indication without lpi");
   a_wake_ok: assert property (tw_rise && wake_symbols_seen && !wr_wake |=> $stable(wake_err))
      else $error("wake error counted with symbols seen");
   a_sig_filter: assert property (sig_s2 == sig_s3 |=> sig_on == $past(sig_s3))
      else $error("signal filter output wrong");

   c_link_up: cover property (link_status == LINK_FAIL ##1 link_status == LINK_OK);
   c_lpi_fail: cover property (lpi_fail);
   c_ready: cover property (link_status == LINK_READY);
   c_fef_cycle: cover property (fef_go && fef_last);
   c_wake_err: cover property (wake_bad);

endmodule
`default_nettype wire

/* File: verification/lpi_an_model.sv */
// auto-negotiation stand-in: answers link_status with link_control.
// assumes the monitor's clk and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module lpi_an_model (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       hold_off,
   input  wire lpi_link_pkg::link_status_t link_status,
   output var lpi_link_pkg::link_control_t link_control
);
   import lpi_link_pkg::*;
   always @(posedge clk) begin
      if (rst) begin
         link_control <= CTL_SCAN;
      end else if (hold_off) begin
         link_control <= CTL_DISABLE;
      end else if (link_status == LINK_READY) begin
         link_control <= CTL_ENABLE;
      end else if (link_status == LINK_FAIL) begin
         link_control <= CTL_SCAN;
      end
   end
endmodule
`default_nettype wire

/* File: verification/lpi_link_monitor_tb.sv */
// testbench for the lpi link monitor with an auto-negotiation stand-in.
// assumes shortened timer parameters; queued expectations are checked at the falling edge, waits and timer lengths just after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module lpi_link_monitor_tb;
   import lpi_link_pkg::*;
   localparam int TN [NUM_TMR] = '{RX_TI_CYC, 50, 30, RX_TW_CYC, 40, 25, LINK_FAIL_CYC};
   typedef struct {int sel; logic [31:0] v;} note_t;
   logic clk = 0, rst = 1, sig = 0, hold_off = 0, lpi_fail = 0, rx_lpi = 0, rx_lq = 0;
   logic tx_lpi = 0, tx_lq = 0, wake_seen = 0, reg_wr = 0, reg_rd = 0;
   logic [4:0]  tx_bits = '0, fef, d;
   logic [6:0]  tstart = '0, texp;
   logic [7:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic        rx_quiet, tx_quiet, refresh, enter_quiet;
   link_status_t  link_status;
   link_control_t link_control;
   note_t q[$];
   note_t nt;
   int num_errors = 0, num_checks = 0, n;

   lpi_an_model i_an (.clk(clk), .rst(rst), .hold_off(hold_off), .link_status(link_status),
      .link_control(link_control));
   lpi_link_monitor #(.QUALIFY_CYCLES(23'h14), .RX_TQ_CYCLES(23'h32), .RX_TS_CYCLES(23'h1e),
      .TX_TQ_CYCLES(23'h28), .TX_TS_CYCLES(23'h19)
   ) i_dut (.clk(clk), .rst(rst), .signal_status(sig), .link_control(link_control),
      .lpi_link_fail(lpi_fail), .rx_lpi(rx_lpi), .rx_line_quiet(rx_lq), .tx_lpi(tx_lpi),
      .tx_line_quiet(tx_lq), .wake_symbols_seen(wake_seen), .tx_code_bits(tx_bits),
      .timer_start(tstart), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .link_status(link_status), .fef_code_bits(fef), .rx_quiet(rx_quiet),
      .tx_quiet(tx_quiet), .timer_expired(texp), .tx_refresh_wake(refresh),
      .tx_enter_quiet(enter_quiet), .reg_rdata(reg_rdata));

   initial begin
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] seen(int s);
      case (s)
         0: return 32'(link_status);
         1: return 32'(fef);
         2: return 32'(rx_quiet);
         3: return 32'(tx_quiet);
         4: return 32'(texp);
         5: return reg_rdata;
         6: return 32'(refresh);
         default: return 32'(enter_quiet);
      endcase
   endfunction

   task automatic final_report();
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic note(int s, logic [31:0] v);
      q.push_back('{s, v});
   endtask

   always @(negedge clk) begin
      while (q.size() > 0) begin
         nt = q.pop_front();
         check(seen(nt.sel), nt.v);
      end
   end

   task automatic cyc(int c);
      repeat (c) @(posedge clk);
   endtask

   task automatic wait_sel(int s, logic [31:0] v, int lim, output int c);
      c = 0;
      while (seen(s) !== v) begin
         @(posedge clk);
         #1;
         c++;
         if (c > lim) begin
            num_errors++;
            final_report();
         end
      end
   endtask

   task automatic wr_reg(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(logic [7:0] a, logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      note(5, e);
   endtask

   task automatic pulse(int i);
      @(posedge clk);
      tstart <= 7'(1 << i);
      @(posedge clk);
      tstart <= '0;
   endtask

   initial begin
      void'($urandom(32'h7aa5));
      cyc(12);
      rst <= 1'b0;
      @(posedge clk);
      note(0, 32'(LINK_FAIL));
      rd_reg(ADDR_CTRL, 32'h3);
      rd_reg(ADDR_WAKE_ERR, 32'h0);
      rd_reg(8'h0c, 32'h0);
      sig <= 1'b1;
      cyc(12);
      sig <= 1'b0;
      cyc(4);
      sig <= 1'b1;
      wait_sel(0, 32'(LINK_READY), 100, n);
      check(32'(n >= 20 && n <= 30), 32'h1);
      wait_sel(0, 32'(LINK_OK), 10, n);
      for (int i = 0; i < 8; i++) begin
         d = 5'($urandom);
         @(posedge clk);
         tx_bits <= d;
         @(posedge clk);
         note(1, 32'(d));
      end
      hold_off <= 1'b1;
      cyc(3);
      note(0, 32'(LINK_FAIL));
      hold_off <= 1'b0;
      wait_sel(0, 32'(LINK_OK), 60, n);
      tx_bits <= 5'h15;
      sig <= 1'b0;
      cyc(6);
      note(0, 32'(LINK_FAIL));
      wait_sel(1, 32'h0f, 40, n);
      for (int i = 0; i < 34; i++) begin
         @(posedge clk);
         note(1, (i % 17 == 16) ? 32'h0f : 32'h1f);
      end
      sig <= 1'b1;
      wait_sel(0, 32'(LINK_OK), 80, n);
      rx_lpi <= 1'b1;
      sig <= 1'b0;
      cyc(8);
      note(0, 32'(LINK_OK));
      note(1, 32'h15);
      rx_lq <= 1'b1;
      cyc(3);
      note(2, 32'h1);
      lpi_fail <= 1'b1;
      cyc(3);
      note(0, 32'(LINK_FAIL));
      lpi_fail <= 1'b0;
      rx_lq <= 1'b0;
      rx_lpi <= 1'b0;
      cyc(3);
      note(2, 32'h0);
      sig <= 1'b1;
      tx_lpi <= 1'b1;
      tx_lq <= 1'b1;
      cyc(3);
      note(3, 32'h1);
      tx_lq <= 1'b0;
      cyc(3);
      note(3, 32'h0);
      for (int i = 0; i < NUM_TMR; i++) begin
         pulse(i);
         n = 0;
         while (texp[i] !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > TN[i] + 10) begin
               num_errors++;
               final_report();
            end
         end
         check(32'(n), 32'(TN[i]));
      end
      cyc(5);
      note(4, 32'h7f);
      note(6, 32'h1);
      note(7, 32'h1);
      pulse(TMR_TX_TS);
      note(4, 32'h5f);
      note(7, 32'h0);
      rd_reg(ADDR_WAKE_ERR, 32'h1);
      wake_seen <= 1'b1;
      pulse(TMR_RX_TW);
      cyc(RX_TW_CYC + 5);
      rd_reg(ADDR_WAKE_ERR, 32'h1);
      wr_reg(ADDR_WAKE_ERR, 32'($urandom));
      rd_reg(ADDR_WAKE_ERR, 32'h0);
      wait_sel(0, 32'(LINK_OK), 80, n);
      pulse(TMR_RX_TQ);
      cyc(1);
      rx_lpi <= 1'b1;
      cyc(40);
      note(0, 32'(LINK_OK));
      cyc(15);
      note(0, 32'(LINK_FAIL));
      wr_reg(ADDR_CTRL, {30'($urandom), 2'h0});
      cyc(2);
      note(4, 32'h0);
      rx_lq <= 1'b1;
      hold_off <= 1'b1;
      cyc(3);
      note(2, 32'h0);
      rx_lpi <= 1'b0;
      wait_sel(0, 32'(LINK_OK), 80, n);
      rd_reg(ADDR_STATUS, 32'h22);
      rd_reg(ADDR_CTRL, 32'h0);
      cyc(2);
      final_report();
   end
endmodule
`default_nettype wire
